/* File: design/srt_rx_term_port.sv */
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
// Contract
// - serial clock from line or reference clock
// - serial data launched on serial clock falls
// - parallel clock 6.48 or 19.44, 19.44 from reference
// - invert setting inverts parallel clock output
// - sonet and 19.44 datacom clock never gaps
// - 6.48 datacom gaps overhead per settings
// - parallel data bit 0 is byte LSB
// - bytes launched on falling, or rising if inverted
// - spe-only: spe indication is low-active gap
// - spe low in toh, high in spe for sonet
// - datacom spe follows overhead-pass for poh
// - markers launched with serial or parallel edge
// - sonet/datacom sync on c1, j1, optional v1
// - spe-only sync on j1, optional v1
// - odd parity, markers included when enabled/datacom
// - valid low while driving, always low at 6.48
// - 19.44 valid only in selected slots
// - bus tri-stated when either guard input low
module srt_rx_term_port (
   // system
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   // register port
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   // source clocks and guard pins
   input  wire logic                 rx_line_clock,
   input  wire logic                 rx_reference_clock,
   input  wire logic                 collision_guard_in_a,
   input  wire logic                 collision_guard_in_b,
   // upstream byte stream
   input  wire srt_pkg::srt_byte_t   in_byte,
   output logic                      byte_req,
   // serial terminal output
   output logic                      serial_rx_term_clock,
   output logic                      serial_rx_term_data,
   // parallel terminal output
   output logic                      parallel_term_clock,
   output logic [7:0]                parallel_term_data,
   output logic                      spe_indication,
   output logic                      frame_sync_pulse,
   output logic                      bus_parity_out,
   output logic                      bus_valid_out_n,
   output logic                      bus_oe_n,
   output logic                      marker_oe_n
);

   typedef struct packed {
      srt_pkg::srt_ctrl_t ctrl;
      logic [31:0]        rdata;
      logic               lc_s1;
      logic               lc_s2;
      logic               rc_s1;
      logic               rc_s2;
      logic               ga_s1;
      logic               ga_s2;
      logic               gb_s1;
      logic               gb_s2;
      logic               src_d;
      logic [2:0]         div;
      logic               pclk_raw;
      logic               gap;
      logic [7:0]         shift;
      logic [2:0]         bitcnt;
      logic               ser_data;
      srt_pkg::srt_bus_t  bus;
      logic [1:0]         slot;
      logic               valid_n;
      logic               byte_req;
   } srt_state_t;

   srt_state_t st_r;
   srt_state_t st_nxt;

   logic       rate_ser;
   logic       rate_648;
   logic       rate_1944;
   logic       use_ref;
   logic       src;
   logic       src_rise;
   logic       src_fall;
   logic       byte_ev;
   logic       is_dc;
   logic       is_spe;
   logic       spe_nxt;
   logic       sync_nxt;
   logic [1:0] slot_nxt;
   logic [1:0] slot_sel;
   logic       slot_ok;

   always_comb begin
      st_nxt   = st_r;
      rate_ser = st_r.ctrl.rate == srt_pkg::SRT_RATE_SERIAL;
      rate_648 = st_r.ctrl.rate == srt_pkg::SRT_RATE_P648;
      rate_1944 = st_r.ctrl.rate == srt_pkg::SRT_RATE_P1944;
      is_dc    = st_r.ctrl.mode == srt_pkg::SRT_MODE_DATACOM;
      is_spe   = st_r.ctrl.mode == srt_pkg::SRT_MODE_SPE;

      // pin synchronisers, second stage is the only reader of the first
      st_nxt.lc_s1 = rx_line_clock;
      st_nxt.lc_s2 = st_r.lc_s1;
      st_nxt.rc_s1 = rx_reference_clock;
      st_nxt.rc_s2 = st_r.rc_s1;
      st_nxt.ga_s1 = collision_guard_in_a;
      st_nxt.ga_s2 = st_r.ga_s1;
      st_nxt.gb_s1 = collision_guard_in_b;
      st_nxt.gb_s2 = st_r.gb_s1;

      // 19.44 rate always runs from the reference clock
      use_ref  = st_r.ctrl.source_reference | rate_1944;
      src      = use_ref ? st_r.rc_s2 : st_r.lc_s2;
      st_nxt.src_d = src;
      src_rise = src & ~st_r.src_d;
      src_fall = ~src & st_r.src_d;

      // byte boundary: one falling edge of the byte clock
      byte_ev = 1'b0;
      if (rate_ser) begin
         st_nxt.pclk_raw = 1'b0;
         if (src_fall) begin
            st_nxt.bitcnt   = st_r.bitcnt + 3'h1;
            st_nxt.ser_data = st_r.shift[7];
            st_nxt.shift    = {st_r.shift[6:0], 1'b0};
            byte_ev         = st_r.bitcnt == srt_pkg::SRT_BIT_LAST;
         end
      end else if (!use_ref || st_r.ctrl.ref_divide_8) begin
         // 51.84 source divided by eight for 6.48
         if (src_rise) begin
            st_nxt.div      = st_r.div + 3'h1;
            st_nxt.pclk_raw = st_nxt.div[2] == 1'b0;
            byte_ev         = st_r.div == srt_pkg::SRT_DIV_FALL;
         end
      end else begin
         // reference already at the parallel rate
         st_nxt.pclk_raw = src;
         byte_ev         = src_fall;
      end

      // markers for the new byte
      if (is_spe) begin
         spe_nxt  = ~in_byte.toh;
         sync_nxt = in_byte.j1 |
                    (in_byte.v1 & st_r.ctrl.v1_sync_enable);
      end else begin
         spe_nxt  = ~in_byte.toh & ~(is_dc & in_byte.poh &
                    ~st_r.ctrl.overhead_pass_enable);
         sync_nxt = in_byte.c1 | in_byte.j1 |
                    (in_byte.v1 & st_r.ctrl.v1_sync_enable);
      end

      // 19.44 slot counter, realigned on the c1 byte
      if (in_byte.c1 || st_r.slot == srt_pkg::SRT_SLOT_LAST) begin
         slot_nxt = srt_pkg::SRT_SLOT_ZERO;
      end else begin
         slot_nxt = st_r.slot + 2'h1;
      end
      slot_sel = {st_r.ctrl.bus_slot_select_1, st_r.ctrl.bus_slot_select_0};
      slot_ok  = slot_nxt == slot_sel &&
                 !(in_byte.stuff_first && !st_r.ctrl.first_stuff_enable) &&
                 !(in_byte.stuff_last && !st_r.ctrl.last_stuff_enable);

      st_nxt.byte_req = byte_ev;
      if (byte_ev) begin
         st_nxt.bus.data = in_byte.data;
         st_nxt.bus.spe  = spe_nxt;
         st_nxt.bus.sync = sync_nxt;
         if (st_r.ctrl.marker_parity_enable || is_dc) begin
            st_nxt.bus.parity = ~^{in_byte.data, spe_nxt,
                                   sync_nxt};
         end else begin
            st_nxt.bus.parity = ~^in_byte.data;
         end
         if (rate_ser) begin
            st_nxt.ser_data = in_byte.data[7];
            st_nxt.shift    = {in_byte.data[6:0], 1'b0};
         end
         st_nxt.slot = slot_nxt;
         // gapping only in 6.48 datacom
         st_nxt.gap = is_dc && rate_648 &&
                      !st_r.ctrl.clock_gap_disable &&
                      (in_byte.toh || (in_byte.poh &&
                       !st_r.ctrl.overhead_pass_enable));
         if (rate_648) begin
            st_nxt.valid_n = 1'b0;
         end else if (rate_1944) begin
            st_nxt.valid_n = ~slot_ok;
         end else begin
            st_nxt.valid_n = 1'b1;
         end
      end
      if (rate_648) begin
         st_nxt.valid_n = 1'b0;
      end

      // register port
      st_nxt.rdata = 32'h0000_0000;
      if (reg_wr && reg_addr == srt_pkg::SRT_ADDR_CTRL) begin
         st_nxt.ctrl = srt_pkg::srt_ctrl_t'(reg_wdata[15:0]);
      end
      if (reg_rd) begin
         case (reg_addr)
            srt_pkg::SRT_ADDR_CTRL: begin
               st_nxt.rdata = {16'h0000, st_r.ctrl};
            end
            srt_pkg::SRT_ADDR_STATUS: begin
               st_nxt.rdata = {22'h000000, st_r.gb_s2, st_r.ga_s2,
                               st_r.valid_n, st_r.gap, st_r.slot,
                               st_r.bitcnt, st_r.pclk_raw};
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r         <= '0;
         st_r.ctrl    <= srt_pkg::SRT_CTRL_RESET;
         st_r.valid_n <= 1'b1;
         st_r.ga_s1   <= 1'b1;
         st_r.ga_s2   <= 1'b1;
         st_r.gb_s1   <= 1'b1;
         st_r.gb_s2   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata            = st_r.rdata;
   assign byte_req             = st_r.byte_req;
   assign serial_rx_term_clock = st_r.src_d;
   assign serial_rx_term_data  = st_r.ser_data;
   // gapped byte holds the clock high, or low if inverted; inversion moves launch to rise
   assign parallel_term_clock  = (st_r.pclk_raw | st_r.gap) ^
                                 st_r.ctrl.parallel_clock_invert;
   assign parallel_term_data   = st_r.bus.data;
   assign spe_indication       = st_r.bus.spe;
   assign frame_sync_pulse     = st_r.bus.sync;
   assign bus_parity_out       = st_r.bus.parity;
   assign bus_valid_out_n      = st_r.valid_n;
   assign bus_oe_n             = (st_r.ctrl.rate == srt_pkg::SRT_RATE_SERIAL) |
                                 st_r.valid_n | ~st_r.ga_s2 |
                                 ~st_r.gb_s2;
   assign marker_oe_n          = (st_r.ctrl.rate != srt_pkg::SRT_RATE_SERIAL) &
                                 (st_r.valid_n | ~st_r.ga_s2 |
                                  ~st_r.gb_s2);

endmodule : srt_rx_term_port

/* File: design/srt_pkg.sv */
package srt_pkg;
   // register map, byte addresses on the plain register port
   localparam logic [3:0] SRT_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] SRT_ADDR_STATUS = 4'h4;
   localparam logic [15:0] SRT_CTRL_RESET = 16'h0000;

   // terminal modes
   localparam logic [1:0] SRT_MODE_SONET   = 2'h0;
   localparam logic [1:0] SRT_MODE_SPE     = 2'h1;
   localparam logic [1:0] SRT_MODE_DATACOM = 2'h2;

   // terminal rates
   localparam logic [1:0] SRT_RATE_SERIAL = 2'h0;
   localparam logic [1:0] SRT_RATE_P648   = 2'h1;
   localparam logic [1:0] SRT_RATE_P1944  = 2'h2;

   // bit counts and dividers
   localparam logic [2:0] SRT_BIT_LAST  = 3'h7;
   localparam logic [2:0] SRT_DIV_FALL  = 3'h3;
   localparam logic [1:0] SRT_SLOT_LAST = 2'h2;
   localparam logic [1:0] SRT_SLOT_ZERO = 2'h0;

   // clock rates in MHz, not referenced by the bench or the design
   localparam real SRT_SER_CLK_MHZ  = 51.84;
   localparam real SRT_P648_CLK_MHZ = 6.48;
   localparam real SRT_P1944_CLK_MHZ = 19.44;

   // control register, bits 15..0 of word at SRT_ADDR_CTRL
   typedef struct packed {
      logic       spare;
      logic       bus_slot_select_1;
      logic       bus_slot_select_0;
      logic       last_stuff_enable;
      logic       first_stuff_enable;
      logic       v1_sync_enable;
      logic       marker_parity_enable;
      logic       overhead_pass_enable;
      logic       clock_gap_disable;
      logic       parallel_clock_invert;
      logic       source_reference;
      logic       ref_divide_8;
      logic [1:0] rate;
      logic [1:0] mode;
   } srt_ctrl_t;

   // one byte time from the upstream overhead terminator
   typedef struct packed {
      logic [7:0] data;
      logic       toh;
      logic       poh;
      logic       c1;
      logic       j1;
      logic       v1;
      logic       stuff_first;
      logic       stuff_last;
   } srt_byte_t;

   // parallel terminal bus
   typedef struct packed {
      logic [7:0] data;
      logic       spe;
      logic       sync;
      logic       parity;
   } srt_bus_t;
endpackage : srt_pkg

/* File: verification/srt_rx_term_port_checker.sv */
`timescale 1ns/10ps
module srt_chk (
   // system and register writes
   input wire logic               clk_sys,
   input wire logic               reset_n,
   input wire logic [3:0]         reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   // sources, guards, stream
   input wire logic               rx_line_clock,
   input wire logic               collision_guard_in_a,
   input wire logic               collision_guard_in_b,
   input wire srt_pkg::srt_byte_t in_byte,
   input wire logic               byte_req,
   // terminal outputs
   input wire logic               serial_rx_term_clock,
   input wire logic               serial_rx_term_data,
   input wire logic               parallel_term_clock,
   input wire logic [7:0]         parallel_term_data,
   input wire logic               spe_indication,
   input wire logic               frame_sync_pulse,
   input wire logic               bus_parity_out,
   input wire logic               bus_valid_out_n,
   input wire logic               bus_oe_n,
   input wire logic               marker_oe_n
);
   srt_pkg::srt_ctrl_t ctrl_r;
   srt_pkg::srt_byte_t b_r;
   logic [2:0]         up_r;
   logic               ok, pr, dc, mk, tk, gd;
   assign ok = up_r == 3'h7;
   assign pr = ctrl_r.rate != srt_pkg::SRT_RATE_SERIAL;
   assign dc = ctrl_r.mode == srt_pkg::SRT_MODE_DATACOM;
   assign mk = ctrl_r.marker_parity_enable | dc;
   assign tk = byte_req & ok & pr;
   assign gd = collision_guard_in_a & collision_guard_in_b;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // settle counter restarts on reset and on each control write
   always_ff @(posedge clk_sys) begin
      b_r <= in_byte;
      if (!reset_n) begin
         ctrl_r <= srt_pkg::SRT_CTRL_RESET;
         up_r <= 3'h0;
      end else if (reg_wr && reg_addr == srt_pkg::SRT_ADDR_CTRL) begin
         ctrl_r <= reg_wdata[15:0];
         up_r <= 3'h0;
      end else if (!ok) begin
         up_r <= up_r + 3'h1;
      end
   end
   par_odd_a: assert property (
      tk |-> ^{parallel_term_data, bus_parity_out,
      mk & spe_indication, mk & frame_sync_pulse})
      else $error("parity not odd");
   data_lsb_a: assert property (
      tk |-> parallel_term_data == b_r.data)
      else $error("parallel byte differs");
   ser_msb_a: assert property (
      byte_req && ok && !pr |-> serial_rx_term_data == b_r.data[7])
      else $error("serial bit not msb");
   spe_mark_a: assert property (
      tk |-> spe_indication == (!b_r.toh && (!dc
      || ctrl_r.overhead_pass_enable || !b_r.poh)))
      else $error("spe marker wrong");
   sync_mark_a: assert property (
      tk |-> frame_sync_pulse == (b_r.j1 || (b_r.v1 && ctrl_r.v1_sync_enable)
      || (b_r.c1 && ctrl_r.mode != srt_pkg::SRT_MODE_SPE)))
      else $error("sync marker wrong");
   valid_low_a: assert property (
      tk && ctrl_r.rate == srt_pkg::SRT_RATE_P648 |-> !bus_valid_out_n)
      else $error("valid high at low rate");
   guard_off_a: assert property (
      (ok && pr && !gd)[*4] |-> bus_oe_n && marker_oe_n)
      else $error("bus driven while guarded");
   drive_valid_a: assert property (
      (ok && pr && gd)[*4] ##0 !bus_oe_n |-> !bus_valid_out_n)
      else $error("bus driven without valid");
   sclk_src_a: assert property (
      ok && !ctrl_r.source_reference && ctrl_r.rate
      != srt_pkg::SRT_RATE_P1944 |->
      serial_rx_term_clock == $past(rx_line_clock, 3))
      else $error("serial clock not from line");
   pclk_edge_a: assert property (
      tk |-> parallel_term_clock == (ctrl_r.parallel_clock_invert ^ (dc
      && ctrl_r.rate == srt_pkg::SRT_RATE_P648
      && !ctrl_r.clock_gap_disable && (b_r.toh
      || (b_r.poh && !ctrl_r.overhead_pass_enable)))))
      else $error("parallel clock level wrong at launch");
   cover property (tk && dc);
   cover property (tk && !bus_valid_out_n
      && ctrl_r.rate == srt_pkg::SRT_RATE_P1944);
   cover property (ok && pr && !gd && bus_oe_n);
endmodule : srt_chk
bind srt_rx_term_port srt_chk chk_u (.clk_sys, .reset_n, .reg_addr,
   .reg_wdata, .reg_wr, .rx_line_clock, .collision_guard_in_a,
   .collision_guard_in_b, .in_byte, .byte_req, .serial_rx_term_clock,
   .serial_rx_term_data, .parallel_term_clock, .parallel_term_data,
   .spe_indication,
   .frame_sync_pulse, .bus_parity_out, .bus_valid_out_n, .bus_oe_n,
   .marker_oe_n);

/* File: verification/srt_src_model.sv */
`timescale 1ns/10ps
module srt_src_model (
   // system and handshake
   input wire logic               clk_sys,
   input wire srt_pkg::srt_byte_t next_byte,
   input wire logic               byte_req,
   // source clocks and upstream byte
   output logic                   rx_line_clock,
   output logic                   rx_reference_clock,
   output srt_pkg::srt_byte_t     in_byte
);
   initial begin
      rx_line_clock = 1'b0;
      rx_reference_clock = 1'b0;
      in_byte = '0;
   end
   always #40 rx_line_clock = ~rx_line_clock;
   // offset keeps reference edges off the system clock edges
   initial begin
      #1;
      forever #26 rx_reference_clock = ~rx_reference_clock;
   end
   // next byte only after the current one was taken
   always @(posedge clk_sys) begin
      if (byte_req) in_byte <= next_byte;
   end
endmodule : srt_src_model

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
   typedef struct packed {
      logic [15:0]        ctrl;
      srt_pkg::srt_byte_t b;
      logic [3:0]         exp;
   } srt_row_t;
   // expected {spe, sync, parity, valid_n}; serial rows use bit 3
   localparam srt_row_t ROWS [9] = '{
      {16'h0004, 8'hA5, 7'b1010000, 4'b0110},
      {16'h0204, 8'h3C, 7'b0000000, 4'b1000},
      {16'h0005, 8'h01, 7'b0101000, 4'b1100},
      {16'h0405, 8'h80, 7'b0000100, 4'b1100},
      {16'h0006, 8'hFF, 7'b0100000, 4'b0010},
      {16'h0106, 8'h00, 7'b0101000, 4'b1110},
      {16'h0004, 8'h0F, 7'b0000100, 4'b1010},
      {16'h0000, 8'h81, 7'b0000000, 4'b1000},
      {16'h0000, 8'h7E, 7'b0000000, 4'b0000}};
   logic clk_sys, reset_n, reg_wr, reg_rd, byte_req, rx_line_clock;
   logic rx_reference_clock, collision_guard_in_a, collision_guard_in_b;
   logic serial_rx_term_clock, serial_rx_term_data, parallel_term_clock;
   logic spe_indication, frame_sync_pulse, bus_parity_out, bus_oe_n;
   logic bus_valid_out_n, marker_oe_n;
   logic [3:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata, rd;
   logic [7:0]         parallel_term_data;
   srt_pkg::srt_byte_t in_byte, next_byte;
   srt_row_t           r;
   int                 n_mismatch = 0, checked = 0, nv;
   srt_rx_term_port dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .rx_line_clock, .rx_reference_clock,
      .collision_guard_in_a, .collision_guard_in_b, .in_byte, .byte_req,
      .serial_rx_term_clock, .serial_rx_term_data, .parallel_term_clock,
      .parallel_term_data, .spe_indication, .frame_sync_pulse,
      .bus_parity_out, .bus_valid_out_n, .bus_oe_n, .marker_oe_n);
   srt_src_model src_u (.clk_sys, .next_byte, .byte_req, .rx_line_clock,
      .rx_reference_clock, .in_byte);
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read
   task automatic wait_req();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (byte_req !== 1'b1 && n < 400);
      if (n >= 400) check(12'h000, 12'h001);
   endtask : wait_req
   task automatic wrap_up();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #300000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {collision_guard_in_a, collision_guard_in_b} = 2'b11;
      next_byte = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      check({bus_valid_out_n, bus_oe_n, byte_req}, 12'h006);
      reg_read(4'h0, rd);
      check(rd[11:0], 12'h000);
      for (int i = 0; i < 9; i++) begin
         r = ROWS[i];
         reg_write(4'h0, {16'h0000, r.ctrl});
         next_byte <= r.b;
         wait_req();
         wait_req();
         if (r.ctrl[3:2] == 2'h0) begin
            check(serial_rx_term_data, r.exp[3]);
         end else begin
            check({parallel_term_data, spe_indication,
               frame_sync_pulse, bus_parity_out, bus_valid_out_n},
               {r.b.data, r.exp});
         end
      end
      reg_read(4'h0, rd);
      check(rd[11:0], 12'h000);
      reg_read(4'h8, rd);
      check(rd[11:0], 12'h000);
      reg_write(4'h0, 32'h0000_0004);
      wait_req();
      check(bus_oe_n, 12'h000);
      @(posedge clk_sys);
      collision_guard_in_a <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      check({bus_oe_n, marker_oe_n}, 12'h003);
      reg_read(4'h4, rd);
      check(rd[9:6], 12'h008);
      @(posedge clk_sys);
      #1;
      check(reg_rdata[11:0], 12'h000);
      @(posedge clk_sys);
      collision_guard_in_a <= 1'b1;
      // clock level at launch: gapped high, inverted high, else low
      next_byte <= 15'h0040;
      reg_write(4'h0, 32'h0000_0006);
      wait_req();
      wait_req();
      check(parallel_term_clock, 12'h001);
      reg_write(4'h0, 32'h0000_0086);
      wait_req();
      wait_req();
      check(parallel_term_clock, 12'h000);
      reg_write(4'h0, 32'h0000_0004);
      wait_req();
      wait_req();
      check(parallel_term_clock, 12'h000);
      reg_write(4'h0, 32'h0000_0044);
      wait_req();
      wait_req();
      check(parallel_term_clock, 12'h001);
      reg_write(4'h0, 32'h0000_0028);
      wait_req();
      nv = 0;
      repeat (6) begin
         wait_req();
         if (bus_valid_out_n === 1'b0) nv++;
      end
      check(nv[11:0], 12'h002);
      // reset in mid-run returns to serial rate with the bus released
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      check({bus_valid_out_n, bus_oe_n, marker_oe_n, byte_req}, 12'h00C);
      reg_read(4'h0, rd);
      check(rd[11:0], 12'h000);
      wrap_up();
   end
endmodule : testbench
